/* hw/jump_reg_barrier.sv */
// jump-register with hazard barrier pipeline control
`timescale 1ns/1ps
`default_nettype none
`include "jump_barrier_params.svh"
// Operation
// - delay-slot instruction executes before control moves to the target.
// - all pending hazards are cleared before the target is fetched.
// - barrier jump is legal in every mode, no coprocessor access needed.
// - instruction bit 10 selects the barrier variant of jump register.
// - with compressed ISA, bit 0 loads insn set select; PC bit 0 zeroed.
// - without compressed ISA, nonzero low two bits fault at target fetch.
// - with compressed ISA, bit0 zero and bit1 one fault at target fetch.
// - only hazards from instructions before the jump must be cleared.
// - instruction hazards clear only via barrier jumps or exception return.
// - family is opcode 000000, function 001000, bits 20..11 zero.
module jump_reg_barrier #(
    parameter int ADDR_W = 32
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              compressed_isa_present,
    input  wire logic              issue_valid,
    input  wire logic [31:0]       issue_insn,
    input  wire logic [ADDR_W-1:0] general_register_data,
    input  wire logic              slot_done,
    input  wire logic              writes_pending,
    input  wire logic              exception_return,
    input  wire logic              execution_barrier,
    output logic [4:0]             general_register_sel,
    output logic                   is_jump,
    output logic                   stall,
    output logic                   fetch_flush,
    output logic                   redirect_valid,
    output logic [ADDR_W-1:0]      redirect_pc,
    output logic                   insn_set_select_bit,
    output logic                   insn_set_write,
    output logic                   addr_error,
    output logic                   clear_exec_hazard,
    output logic                   clear_insn_hazard
);
    // refuse widths that cannot hold the two low alignment bits
    if (ADDR_W < 2) begin : g_addr_w_check
        $error("ADDR_W must be at least 2");
    end

    // decoder results
    logic                           dec_jr;
    logic                           dec_hb;

    // sequencer state and the captured jump
    jump_barrier_pkg::barrier_state_t state_q, state_d;
    logic [ADDR_W-1:0]              target_q, target_d;
    logic                           hb_q, hb_d;
    logic                           mode_q, mode_d;

    // barrier guard counter and its end condition
    logic [7:0]                     drain_q, drain_d;
    logic                           drain_done;
    logic                           go_now;

    // redirect and hazard-clear registers
    logic                           isa_q, isa_d;
    logic                           rv_q, rv_d;
    logic [ADDR_W-1:0]              pc_q, pc_d;
    logic                           ae_q, ae_d;
    logic                           cih_q, cih_d;
    logic                           ceh_q, ceh_d;

    // field decode of the issued word
    jump_decode jump_decode_i (
        .insn             (issue_insn),
        .is_jump_reg      (dec_jr),
        .is_barrier       (dec_hb),
        .source_reg_field (general_register_sel)
    );

    // no privilege check gates the barrier form
    assign is_jump = issue_valid && dec_jr;

    // drain ends when earlier writes are done or the guard count runs out
    assign drain_done = (state_q == jump_barrier_pkg::ST_DRAIN)
        && (!writes_pending || drain_q == `DRAIN_MAX);
    // one cycle in go hands the redirect to the output stage
    assign go_now = state_q == jump_barrier_pkg::ST_GO;

    // next-state computation for the jump sequencer
    always_comb begin
        state_d  = state_q;
        target_d = target_q;
        hb_d     = hb_q;
        mode_d   = mode_q;
        case (state_q)
            jump_barrier_pkg::ST_IDLE: begin
                if (is_jump) begin
                    // capture the target in stage I
                    target_d = general_register_data;
                    hb_d     = dec_hb;
                    mode_d   = compressed_isa_present;
                    state_d  = jump_barrier_pkg::ST_SLOT;
                end
            end
            jump_barrier_pkg::ST_SLOT: begin
                // the delay slot retires before the redirect
                if (slot_done) begin
                    if (hb_q)
                        state_d = jump_barrier_pkg::ST_DRAIN;
                    else
                        state_d = jump_barrier_pkg::ST_GO;
                end
            end
            jump_barrier_pkg::ST_DRAIN: begin
                // wait for earlier state writes; slot writes may still lag
                if (drain_done)
                    state_d = jump_barrier_pkg::ST_GO;
            end
            jump_barrier_pkg::ST_GO: begin
                // next jump may be taken while the redirect is out
                state_d = jump_barrier_pkg::ST_IDLE;
            end
            default: state_d = jump_barrier_pkg::ST_IDLE;
        endcase
    end

    // register stage for the sequencer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q  <= jump_barrier_pkg::ST_IDLE;
            target_q <= '0;
            hb_q     <= 1'b0;
            mode_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            target_q <= target_d;
            hb_q     <= hb_d;
            mode_q   <= mode_d;
        end
    end

    // guard counter: restarts in the slot, counts while the barrier drains
    always_comb begin
        drain_d = drain_q;
        if (state_q == jump_barrier_pkg::ST_SLOT)
            drain_d = 8'h00;
        else if (state_q == jump_barrier_pkg::ST_DRAIN)
            drain_d = drain_q + 8'h01;
    end

    // register stage for the guard counter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drain_q <= 8'h00;
        end else begin
            drain_q <= drain_d;
        end
    end

    // hazard clears from the drain, a plain execution barrier or a return
    always_comb begin
        cih_d = exception_return || drain_done;
        ceh_d = execution_barrier || exception_return || drain_done;
    end

    // register stage for the hazard-clear pulses
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cih_q <= 1'b0;
            ceh_q <= 1'b0;
        end else begin
            cih_q <= cih_d;
            ceh_q <= ceh_d;
        end
    end

    // redirect target, set select and alignment fault for the go cycle
    always_comb begin
        rv_d  = go_now;
        pc_d  = pc_q;
        isa_d = isa_q;
        ae_d  = 1'b0;
        if (go_now) begin
            if (mode_q) begin
                pc_d  = {target_q[ADDR_W-1:1], 1'b0};
                isa_d = target_q[0];
                ae_d  = !target_q[0] && target_q[1];
            end else begin
                pc_d = target_q;
                ae_d = target_q[1:0] != 2'b00;
            end
        end
    end

    // register stage for the redirect outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rv_q  <= 1'b0;
            pc_q  <= '0;
            isa_q <= 1'b0;
            ae_q  <= 1'b0;
        end else begin
            rv_q  <= rv_d;
            pc_q  <= pc_d;
            isa_q <= isa_d;
            ae_q  <= ae_d;
        end
    end

    // fetch is held while a barrier drains; wrong-path fetches are dropped in the redirect cycle
    assign stall = state_q == jump_barrier_pkg::ST_DRAIN;
    assign fetch_flush = rv_q;

    // redirect outputs, registered from the go cycle and valid one cycle later
    assign redirect_valid = rv_q;
    assign redirect_pc = pc_q;
    assign insn_set_select_bit = isa_q;
    assign insn_set_write = rv_q && mode_q;
    assign addr_error = ae_q;

    // hazard-clear pulses
    assign clear_exec_hazard = ceh_q;
    assign clear_insn_hazard = cih_q;
endmodule
`default_nettype wire

/* hw/jump_barrier_params.svh */
// constants for the jump-register hazard barrier control block
`ifndef JUMP_BARRIER_PARAMS_SVH
`define JUMP_BARRIER_PARAMS_SVH
`define OPC_MSB          31
`define OPC_LSB          26
`define SRC_MSB          25
`define SRC_LSB          21
`define ZERO_MSB         20
`define ZERO_LSB         11
`define BARRIER_BIT      10
`define FUNC_MSB         5
`define FUNC_LSB         0
`define OPC_SPECIAL      6'h00
`define FUNC_JUMP_REG    6'h08
`define LINK_REG         5'h1f
`define DRAIN_MAX        8'hff
`endif

/* hw/jump_barrier_pkg.sv */
// types for the jump-register hazard barrier control block
package jump_barrier_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SLOT  = 2'b01,
        ST_DRAIN = 2'b10,
        ST_GO    = 2'b11
    } barrier_state_t;
endpackage

/* hw/jump_decode.sv */
// decoder for the jump-register family
`timescale 1ns/1ps
`default_nettype none
`include "jump_barrier_params.svh"
module jump_decode (
    input  wire logic [31:0] insn,
    output logic             is_jump_reg,
    output logic             is_barrier,
    output logic [4:0]       source_reg_field
);
    // opcode, function and zero field match the jump-register family
    always_comb begin
        is_jump_reg = (insn[`OPC_MSB:`OPC_LSB] == `OPC_SPECIAL)
            && (insn[`FUNC_MSB:`FUNC_LSB] == `FUNC_JUMP_REG)
            && (insn[`ZERO_MSB:`ZERO_LSB] == 10'h000);
        is_barrier = is_jump_reg && insn[`BARRIER_BIT];
        source_reg_field = insn[`SRC_MSB:`SRC_LSB];
    end
endmodule
`default_nettype wire

/* dv/jump_barrier_props.sv */
// assertions on the ports of the jump-register barrier block
`timescale 1ns/1ps
`default_nettype none
`include "jump_barrier_params.svh"
module jump_barrier_props #(
    parameter int ADDR_W = 32
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              exception_return,
    input wire logic              execution_barrier,
    input wire logic              issue_valid,
    input wire logic [31:0]       issue_insn,
    input wire logic              is_jump,
    input wire logic              stall,
    input wire logic              writes_pending,
    input wire logic              fetch_flush,
    input wire logic              redirect_valid,
    input wire logic [ADDR_W-1:0] redirect_pc,
    input wire logic              insn_set_select_bit,
    input wire logic              insn_set_write,
    input wire logic              addr_error,
    input wire logic              clear_exec_hazard,
    input wire logic              clear_insn_hazard
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // consecutive drain cycles, compared with the guard count
    logic [7:0] drain_seen_q;
    always_ff @(posedge core_clk) begin
        if (rst || !stall)
            drain_seen_q <= 8'h00;
        else
            drain_seen_q <= drain_seen_q + 8'h01;
    end

    // barrier ordering, redirect and fault checks
    redir_flush_a: assert property (
        fetch_flush |-> redirect_valid ##1 !fetch_flush)
        else $error("flush not a one-cycle redirect pulse");
    clear_pair_a: assert property (
        clear_insn_hazard |-> clear_exec_hazard)
        else $error("insn clear without exec clear");
    clear_first_a: assert property (
        clear_insn_hazard && $past(stall) && !stall |=> redirect_valid)
        else $error("redirect not after clear");
    drain_hold_a: assert property (
        stall && writes_pending && !exception_return
        && drain_seen_q != `DRAIN_MAX |=> !clear_insn_hazard)
        else $error("clear while writes pending");
    drain_exit_a: assert property (
        stall && !writes_pending |=> clear_insn_hazard)
        else $error("drain did not end");
    pc_even_a: assert property (
        redirect_valid && insn_set_write |-> !redirect_pc[0])
        else $error("pc bit 0 not cleared");
    err_plain_a: assert property (
        redirect_valid && !insn_set_write
        |-> addr_error == (redirect_pc[1:0] != 2'h0))
        else $error("plain mode fault wrong");
    err_comp_a: assert property (
        redirect_valid && insn_set_write
        |-> addr_error == (redirect_pc[1] && !insn_set_select_bit))
        else $error("compressed mode fault wrong");
    family_decode_a: assert property (
        is_jump == (issue_valid && issue_insn[31:26] == 6'h00
        && issue_insn[20:11] == 10'h000 && issue_insn[5:0] == 6'h08))
        else $error("jump decode wrong");
    exec_only_a: assert property (
        execution_barrier && !exception_return && !stall
        |=> clear_exec_hazard && !clear_insn_hazard)
        else $error("execution barrier cleared insn hazards");
    return_clear_a: assert property (
        exception_return |=> clear_insn_hazard && clear_exec_hazard)
        else $error("exception return did not clear");
endmodule
bind jump_reg_barrier jump_barrier_props #(
    .ADDR_W (ADDR_W)
) jump_barrier_props_i (
    .core_clk            (core_clk),
    .rst                 (rst),
    .exception_return    (exception_return),
    .execution_barrier   (execution_barrier),
    .issue_valid         (issue_valid),
    .issue_insn          (issue_insn),
    .is_jump             (is_jump),
    .stall               (stall),
    .writes_pending      (writes_pending),
    .fetch_flush         (fetch_flush),
    .redirect_valid      (redirect_valid),
    .redirect_pc         (redirect_pc),
    .insn_set_select_bit (insn_set_select_bit),
    .insn_set_write      (insn_set_write),
    .addr_error          (addr_error),
    .clear_exec_hazard   (clear_exec_hazard),
    .clear_insn_hazard   (clear_insn_hazard)
);
`default_nettype wire

/* dv/test_jump_reg_barrier.sv */
// testbench for the jump-register barrier block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_jump_reg_barrier;
    logic core_clk = 0, rst = 1, cmp = 0, issue_valid = 0, slot_done = 0;
    logic wp = 0, is_jump, stall, flush, rv, isb, isw, aerr, cx, ci;
    logic xr = 0, eb = 0;
    logic [31:0] insn = 0, data = 0, pc;
    logic [4:0]  sel;
    logic        saw_c, saw_s, saw_x;
    int          err_total = 0, n_compared = 0;
    jump_reg_barrier jump_reg_barrier_i (.core_clk(core_clk), .rst(rst),
        .compressed_isa_present(cmp), .issue_valid(issue_valid),
        .issue_insn(insn), .general_register_data(data), .slot_done(slot_done),
        .writes_pending(wp), .exception_return(xr), .execution_barrier(eb),
        .general_register_sel(sel), .is_jump(is_jump), .stall(stall),
        .fetch_flush(flush), .redirect_valid(rv), .redirect_pc(pc),
        .insn_set_select_bit(isb), .insn_set_write(isw), .addr_error(aerr),
        .clear_exec_hazard(cx), .clear_insn_hazard(ci));
    // clock
    always #5 core_clk = ~core_clk;
    // one jump: issue, delay slot retires, drain for hold cycles, redirect
    task automatic jump(input logic hb, input logic [31:0] t, input logic c,
                        input int hold);
        int n;
        @(posedge core_clk);
        issue_valid <= 1'b1;
        insn <= 32'h0080_0008 | {21'h0, hb, 10'h0};
        data <= t;
        cmp <= c;
        wp <= (hold > 0);
        @(posedge core_clk);
        issue_valid <= 1'b0;
        @(posedge core_clk);
        slot_done <= 1'b1;
        @(posedge core_clk);
        slot_done <= 1'b0;
        saw_c = 0;
        saw_s = 0;
        saw_x = 0;
        for (n = 0; n < 300 && rv !== 1'b1; n++) begin
            @(posedge core_clk);
            if (n >= hold) wp <= 1'b0;
            #1;
            if (ci === 1'b1) saw_c = 1;
            if (cx === 1'b1) saw_x = 1;
            if (stall === 1'b1 && ci !== 1'b1 && rv !== 1'b1) saw_s = 1;
        end
        if (n >= 300) err_total++;
    endtask
    task automatic t_plain;
        jump(1'b0, 32'h0000_0100, 1'b0, 0);
        `CHK("pc", 32'h0000_0100, pc)
        `CHK("err", 1'b0, aerr)
        `CHK("clear", 1'b0, saw_c)
        `CHK("xclear", 1'b0, saw_x)
        `CHK("flush", 1'b1, flush)
        `CHK("isw", 1'b0, isw)
        jump(1'b0, 32'h0000_0102, 1'b0, 0);
        `CHK("err", 1'b1, aerr)
    endtask
    task automatic t_comp;
        jump(1'b1, 32'h0000_0201, 1'b1, 0);
        `CHK("pc", 32'h0000_0200, pc)
        `CHK("isb", 1'b1, isb)
        `CHK("isw", 1'b1, isw)
        `CHK("err", 1'b0, aerr)
        jump(1'b1, 32'h0000_0202, 1'b1, 0);
        `CHK("err", 1'b1, aerr)
    endtask
    task automatic t_drain;
        jump(1'b1, 32'h0000_0400, 1'b0, 6);
        `CHK("stall", 1'b1, saw_s)
        `CHK("clear", 1'b1, saw_c)
        `CHK("xclear", 1'b1, saw_x)
        `CHK("pc", 32'h0000_0400, pc)
    endtask
    task automatic t_decode;
        @(posedge core_clk);
        issue_valid <= 1'b1;
        insn <= 32'h0080_1008;
        #1;
        `CHK("jump", 1'b0, is_jump)
        `CHK("sel", 5'h04, sel)
        @(posedge core_clk);
        issue_valid <= 1'b0;
    endtask
    // execution barrier alone, then an exception return
    task automatic t_other;
        @(posedge core_clk);
        eb <= 1'b1;
        @(posedge core_clk);
        eb <= 1'b0;
        #1;
        `CHK("xclear", 1'b1, cx)
        `CHK("iclear", 1'b0, ci)
        @(posedge core_clk);
        xr <= 1'b1;
        @(posedge core_clk);
        xr <= 1'b0;
        #1;
        `CHK("iclear", 1'b1, ci)
        `CHK("xclear", 1'b1, cx)
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_plain();
        t_comp();
        t_drain();
        t_decode();
        t_other();
        tally_and_finish();
    end
endmodule
`default_nettype wire
